// ===== design/cwg_pkg.sv
// constants, register map and state types of the compare waveform generator
package cwg_pkg;
	localparam int CWG_CHANNELS = 8;
	localparam int CWG_TIMER_W = 16;
	localparam logic [7:0] CWG_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CWG_ADDR_PERIOD = 8'h04;
	localparam logic [7:0] CWG_ADDR_FUNC_EN = 8'h08;
	localparam logic [7:0] CWG_ADDR_FUNC_SEL = 8'h0C;
	localparam logic [7:0] CWG_ADDR_IRQ = 8'h10;
	localparam logic [7:0] CWG_ADDR_COUNT = 8'h14;
	localparam logic [7:0] CWG_ADDR_OUTS = 8'h18;
	localparam logic [7:0] CWG_ADDR_CH_CTL = 8'h20;
	localparam logic [7:0] CWG_ADDR_CH_CMP = 8'h40;
	localparam logic [7:0] CWG_CH_BLOCK_MASK = 8'hE0;
	localparam int CWG_CTRL_RUN_POS = 0;
	localparam int CWG_CTRL_RST_POS = 1;
	localparam logic [2:0] CWG_RST_FREE = 3'h0;
	localparam logic [2:0] CWG_RST_CH0 = 3'h1;
	localparam logic [2:0] CWG_RST_PERIOD = 3'h4;
	localparam int CWG_CTL_MODE_POS = 0;
	localparam int CWG_CTL_DEFLVL_POS = 2;
	localparam int CWG_CTL_INV_POS = 3;
	localparam logic [1:0] CWG_MODE_SINGLE = 2'h0;
	localparam logic [1:0] CWG_MODE_PHASE = 2'h2;
	localparam logic [15:0] CWG_TIMER_ZERO = 16'h0000;
	localparam logic [15:0] CWG_TIMER_ONE = 16'h0001;
	localparam logic [31:0] CWG_RDATA_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		CWG_WAVE_OFF = 3'b001,
		CWG_WAVE_SINGLE = 3'b010,
		CWG_WAVE_PHASE = 3'b100
	} cwg_wave_t;

	typedef struct packed {
		logic run;
		logic [2:0] rstSel;
		logic [15:0] period;
		logic [7:0] funcEn;
		logic [7:0] funcSel;
		logic [7:0] irqFlags;
		logic [15:0] count;
		logic rstPend;
		logic [7:0][3:0] chCtl;
		logic [7:0][15:0] cmp;
		logic [31:0] rdata;
	} cwg_regs_t;

	typedef struct packed {
		logic wave;
		logic pin;
	} cwg_chan_t;
endpackage : cwg_pkg

// ===== design/cwg_channel.sv
// one compare channel: match detection and waveform shaping
`timescale 1ns/1ps
module cwg_channel
	import cwg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic timerRun,
	input wire logic [cwg_pkg::CWG_TIMER_W-1:0] count,
	input wire logic [cwg_pkg::CWG_TIMER_W-1:0] compare,
	input wire logic enable,
	input wire logic waveSel,
	input wire logic blocked,
	input wire logic [1:0] mode,
	input wire logic defLevel,
	input wire logic invert,
	output logic matchHit,
	output logic outPin
);
	import cwg_pkg::*;

	cwg_chan_t state_reg;
	cwg_chan_t state_next;
	cwg_wave_t waveMode;
	logic active;

	////////////////////////////////////////////////////////////////
	// mode decode and match
	always_comb
	begin
		active = enable && waveSel && !blocked;
		if (!active)
			waveMode = CWG_WAVE_OFF;
		else if (mode == CWG_MODE_SINGLE)
			waveMode = CWG_WAVE_SINGLE;
		else if (mode == CWG_MODE_PHASE)
			waveMode = CWG_WAVE_PHASE;
		else
			waveMode = CWG_WAVE_OFF;
	end

	assign matchHit = active && timerRun && (count == compare);

	////////////////////////////////////////////////////////////////
	// waveform state
	always_comb
	begin
		state_next = state_reg;
		unique case (waveMode)
			CWG_WAVE_OFF:
			begin
				state_next.wave = defLevel;
			end
			CWG_WAVE_SINGLE:
			begin
				if (matchHit)
					state_next.wave = !defLevel;
				else if (timerRun && count == CWG_TIMER_ZERO)
					state_next.wave = defLevel;
			end
			CWG_WAVE_PHASE:
			begin
				if (matchHit)
					state_next.wave = !state_reg.wave;
			end
		endcase
		state_next.pin = state_next.wave ^ invert;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign outPin = state_reg.pin;
endmodule : cwg_channel

// ===== design/cwg_top.sv
// compare waveform generator: base timer, APB registers and eight channels
// Notes on behaviour
// - single-phase, no inversion: output goes high when timer equals compare
// - single-phase: output returns low when the timer reaches zero
// - free-running single-phase: period 65536, default m clocks, inverse rest
// - free-running whenever reset-select is neither the ch0-match value nor the period value
// - only ch0-match select bit set: timer clears after channel 0 match
// - only period select bit set: timer clears after period register match
// - match-reset single-phase: period n+2, default m, inverse n+2-m
// - writing function-enable to 1 starts the channel waveform
// - writing function-enable to 0 stops the channel waveform
// - channel irq flag set when timer equals that channel's compare value while the channel is active and the timer runs
// - phase-delayed: output toggles on each compare match
// - phase-delayed free-running: period 2 x 65536, equal halves
// - default-level bit gives starting level; zero means low
// - inversion bit drives the pin with the complement of the waveform
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cwg_top
	import cwg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [cwg_pkg::CWG_CHANNELS-1:0] compareOutputPin
);
	import cwg_pkg::*;

	cwg_regs_t regs_reg;
	cwg_regs_t regs_next;
	logic [CWG_CHANNELS-1:0] matchHit;
	logic setupRd;
	logic accessWr;
	logic ch0Reset;
	logic [7:0] wIrq;

	////////////////////////////////////////////////////////////////
	// address decode
	function automatic logic isMapped(input logic [7:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr[1:0] == 2'h0)
		begin
			if (addr <= CWG_ADDR_OUTS)
				hit = 1'b1;
			else if ((addr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CTL)
				hit = 1'b1;
			else if ((addr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CMP)
				hit = 1'b1;
		end
		return hit;
	endfunction : isMapped

	function automatic logic [31:0] readWord(input cwg_regs_t r,
		input logic [7:0] addr, input logic [7:0] pins);
		logic [31:0] d;
		logic [2:0] idx;
		d = 32'h0000_0000;
		idx = addr[4:2];
		if ((addr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CTL)
			d[3:0] = r.chCtl[idx];
		else if ((addr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CMP)
			d[15:0] = r.cmp[idx];
		else
		begin
			unique case (addr)
				CWG_ADDR_CTRL: d[3:0] = {r.rstSel, r.run};
				CWG_ADDR_PERIOD: d[15:0] = r.period;
				CWG_ADDR_FUNC_EN: d[7:0] = r.funcEn;
				CWG_ADDR_FUNC_SEL: d[7:0] = r.funcSel;
				CWG_ADDR_IRQ: d[7:0] = r.irqFlags;
				CWG_ADDR_COUNT: d[15:0] = r.count;
				CWG_ADDR_OUTS: d[7:0] = pins;
				default: d = 32'h0000_0000;
			endcase
		end
		return d;
	endfunction : readWord

	assign setupRd = psel && !penable && !pwrite;
	assign accessWr = psel && penable && pwrite && isMapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !isMapped(paddr);
	assign prdata = regs_reg.rdata;
	assign ch0Reset = (regs_reg.rstSel == CWG_RST_CH0);

	////////////////////////////////////////////////////////////////
	// registers, base timer and irq flags
	always_comb
	begin
		regs_next = regs_reg;
		wIrq = 8'h00;
		// misaligned or unmapped reads return zero, even inside a channel block
		if (setupRd)
			regs_next.rdata = isMapped(paddr)
				? readWord(regs_reg, paddr, compareOutputPin) : CWG_RDATA_RESET;
		if (accessWr)
		begin
			if ((paddr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CTL)
				regs_next.chCtl[paddr[4:2]] = pwdata[3:0];
			else if ((paddr & CWG_CH_BLOCK_MASK) == CWG_ADDR_CH_CMP)
				regs_next.cmp[paddr[4:2]] = pwdata[15:0];
			else
			begin
				unique case (paddr)
					CWG_ADDR_CTRL:
					begin
						regs_next.run = pwdata[CWG_CTRL_RUN_POS];
						regs_next.rstSel = pwdata[CWG_CTRL_RST_POS +: 3];
					end
					CWG_ADDR_PERIOD: regs_next.period = pwdata[15:0];
					CWG_ADDR_FUNC_EN: regs_next.funcEn = pwdata[7:0];
					CWG_ADDR_FUNC_SEL: regs_next.funcSel = pwdata[7:0];
					CWG_ADDR_IRQ: wIrq = pwdata[7:0];
					default: wIrq = 8'h00;
				endcase
			end
		end
		// write one clears; a match in the same cycle wins
		regs_next.irqFlags = (regs_reg.irqFlags & ~wIrq) | matchHit;
		regs_next.rstPend = 1'b0;
		if (regs_reg.run)
		begin
			if (regs_reg.rstPend)
				regs_next.count = CWG_TIMER_ZERO;
			else
				regs_next.count = regs_reg.count + CWG_TIMER_ONE;
			// clear lands two clocks after the match, giving an n+2 period
			if (!regs_reg.rstPend)
			begin
				if (ch0Reset && regs_reg.count == regs_reg.cmp[0])
					regs_next.rstPend = 1'b1;
				else if (regs_reg.rstSel == CWG_RST_PERIOD
					&& regs_reg.count == regs_reg.period)
					regs_next.rstPend = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			regs_reg <= '0;
			regs_reg.rdata <= CWG_RDATA_RESET;
		end
		else
			regs_reg <= regs_next;
	end

	////////////////////////////////////////////////////////////////
	// channels
	for (genvar j = 0; j < CWG_CHANNELS; j++)
	begin : gChan
		cwg_channel uChan (
			.clk(clk),
			.rst_b(rst_b),
			.timerRun(regs_reg.run),
			.count(regs_reg.count),
			.compare(regs_reg.cmp[j]),
			.enable(regs_reg.funcEn[j]),
			.waveSel(!regs_reg.funcSel[j]),
			.blocked((j == 0) && ch0Reset),
			.mode(regs_reg.chCtl[j][CWG_CTL_MODE_POS +: 2]),
			.defLevel(regs_reg.chCtl[j][CWG_CTL_DEFLVL_POS]),
			.invert(regs_reg.chCtl[j][CWG_CTL_INV_POS]),
			.matchHit(matchHit[j]),
			.outPin(compareOutputPin[j])
		);
	end
endmodule : cwg_top

// ===== tb/cwg_monitor.sv
// port assertions of the compare waveform generator
`timescale 1ns/1ps
module cwg_monitor
	import cwg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [cwg_pkg::CWG_CHANNELS-1:0] compareOutputPin
);
	logic [7:0] enReg;
	logic [7:0] lvlReg;
	logic wr;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// shadow of enables and idle levels
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			{enReg, lvlReg} <= 16'h0000;
		else if (wr && paddr == CWG_ADDR_FUNC_EN)
			enReg <= pwdata[7:0];
		else if (wr && (paddr & 8'hE3) == CWG_ADDR_CH_CTL)
			lvlReg[paddr[4:2]] <= pwdata[2] ^ pwdata[3];
	property p_idle;
		(enReg == $past(enReg, 2) && lvlReg == $past(lvlReg, 2))
			|-> ((compareOutputPin ^ lvlReg) & ~enReg) == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_rst; $rose(rst_b) |-> prdata == 0 && compareOutputPin == 0; endproperty
	a_rst: assert property (p_rst) else $error("reset level");
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_mis; psel && penable && paddr[1:0] != 0 |-> pslverr; endproperty
	a_mis: assert property (p_mis) else $error("no error");
	property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_zero; psel && !penable && !pwrite && paddr[1:0] != 0 |=> prdata == 0; endproperty
	a_zero: assert property (p_zero) else $error("unmapped data");
	property p_outs;
		psel && !penable && !pwrite && paddr == CWG_ADDR_OUTS
			|=> prdata == {24'h000000, $past(compareOutputPin)};
	endproperty
	a_outs: assert property (p_outs) else $error("pin readback");
endmodule : cwg_monitor

// ===== tb/cwg_load_model.sv
// load on the outputs: length of the last high and low run of each pin
`timescale 1ns/1ps
module cwg_load_model
	import cwg_pkg::*;
(
	input wire logic clk,
	input wire logic [cwg_pkg::CWG_CHANNELS-1:0] pins,
	output logic [7:0][15:0] hiLen,
	output logic [7:0][15:0] loLen
);
	logic [7:0][15:0] runLen = '0;
	logic [7:0] lastPin = '0;
	initial {hiLen, loLen} = '0;
	always @(posedge clk)
		for (int j = 0; j < 8; j++)
		begin
			runLen[j] <= (pins[j] !== lastPin[j]) ? 16'h0001 : runLen[j] + 16'h0001;
			lastPin[j] <= pins[j];
			if (pins[j] !== lastPin[j] && lastPin[j])
				hiLen[j] <= runLen[j];
			if (pins[j] !== lastPin[j] && !lastPin[j])
				loLen[j] <= runLen[j];
		end
endmodule : cwg_load_model

// ===== tb/test_compare_waveform_generator.sv
// bench: APB tasks and waveform scenarios
`timescale 1ns/1ps
module test_compare_waveform_generator;
	import cwg_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, errSeen;
	logic [7:0] paddr;
	logic [7:0] pins;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0][15:0] hiLen, loLen;
	int failCount = 0;
	int comparisons = 0;
	cwg_top dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compareOutputPin(pins));
	cwg_load_model load_u (.clk(clk), .pins(pins), .hiLen(hiLen), .loLen(loLen));
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		errSeen = pslverr;
		{psel, penable} <= 2'b00;
	endtask : xfer
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic finalReport();
		$display("compares=%0d mismatches=%0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finalReport
	// ch2 phase-delayed, ch3 high start, ch4 inverted
	task automatic runs(input logic [15:0] p);
		repeat (70) @(posedge clk);
		chk(32'(loLen[1]), 32'h3);
		chk(32'(hiLen[1]), 32'(p - 16'h3));
		chk(32'({hiLen[2], loLen[2]}), {p, p});
		chk(32'({hiLen[3], loLen[3]}), {16'h3, p - 16'h3});
		chk(32'({hiLen[4], loLen[4]}), {16'h3, p - 16'h3});
	endtask : runs
	initial
	begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		xfer(0, CWG_ADDR_CTRL, 0);
		chk(rd, 32'h0);
		xfer(0, 8'h02, 0);
		chk({rd[30:0], errSeen}, 32'h1);
		xfer(1, CWG_ADDR_PERIOD, 32'hA);
		xfer(1, CWG_ADDR_CTRL, 32'h9);
		for (int j = 1; j < 5; j++)
		begin
			xfer(1, CWG_ADDR_CH_CTL + 8'(4 * j), (j == 2) ? 2 : (j == 3) ? 4 : (j == 4) ? 8 : 0);
			xfer(1, CWG_ADDR_CH_CMP + 8'(4 * j), (j == 2) ? 5 : 3);
		end
		xfer(0, 8'h29, 0);
		chk({rd[30:0], errSeen}, 32'h1);
		xfer(1, CWG_ADDR_FUNC_EN, 32'h1E);
		runs(16'hC);
		xfer(0, CWG_ADDR_IRQ, 0);
		chk(rd & 32'h1E, 32'h1E);
		xfer(1, CWG_ADDR_CH_CMP, 32'hB);
		xfer(1, CWG_ADDR_CTRL, 32'h3);
		xfer(1, CWG_ADDR_FUNC_EN, 32'h1F);
		runs(16'hD);
		xfer(0, CWG_ADDR_IRQ, 0);
		chk(rd & 32'h1F, 32'h1E);
		// free-running timer: one single-phase period spans the whole count range
		xfer(1, CWG_ADDR_CTRL, 32'h1);
		repeat (65600) @(posedge clk);
		chk(32'({hiLen[1], loLen[1]}), 32'hFFFD_0003);
		chk(32'({hiLen[3], loLen[3]}), 32'h0003_FFFD);
		chk(32'({hiLen[4], loLen[4]}), 32'h0003_FFFD);
		xfer(1, CWG_ADDR_FUNC_SEL, 32'h1E);
		repeat (4) @(posedge clk);
		xfer(0, CWG_ADDR_OUTS, 0);
		chk(rd & 32'h1E, 32'h18);
		xfer(1, CWG_ADDR_FUNC_SEL, 0);
		xfer(1, CWG_ADDR_FUNC_EN, 0);
		repeat (4) @(posedge clk);
		xfer(0, CWG_ADDR_OUTS, 0);
		chk(rd, 32'h18);
		finalReport();
	end
	initial
	begin
		repeat (70000) @(posedge clk);
		failCount++;
		finalReport();
	end
endmodule : test_compare_waveform_generator
bind cwg_top cwg_monitor mon_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .compareOutputPin(compareOutputPin));
